//--- rtl/fdd_pkg.sv
package fdd_pkg;

	// Scan clock rate and comparator settling time per reference level.
	localparam int unsigned CLK_MHZ    = 100;
	localparam int unsigned SETTLE_NS  = 1000;
	// Least time, so the count rounds up to whole cycles.
	localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned CNT_W      = 8;

	// Number of monitored points.
	localparam int unsigned NPTS = 16;

	// Register byte offsets.
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_OPEN_THR  = 8'h04;
	localparam logic [7:0] ADDR_ALARM_THR = 8'h08;
	localparam logic [7:0] ADDR_SHORT_THR = 8'h0c;
	localparam logic [7:0] ADDR_ALARM_WD  = 8'h10;
	localparam logic [7:0] ADDR_LINE_OK   = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h18;
	localparam logic [7:0] ADDR_IRQ_MASK  = 8'h1c;
	localparam logic [7:0] ADDR_SCAN_STAT = 8'h20;

	// Control register fields.
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam logic        CTRL_RST    = 1'b1;

	// Threshold reset values, loop current in microamps.
	localparam logic [15:0] OPEN_THR_RST  = 16'h0bb8;
	localparam logic [15:0] ALARM_THR_RST = 16'h2904;
	localparam logic [15:0] SHORT_THR_RST = 16'h4e20;

	// Interrupt status and mask fields.
	localparam int unsigned IRQ_ALARM_BIT = 0;
	localparam int unsigned IRQ_LINE_BIT  = 1;
	localparam int unsigned IRQ_MOD_BIT   = 2;
	localparam int unsigned IRQ_SCAN_BIT  = 3;
	localparam int unsigned IRQ_W         = 4;
	localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;

	// Scan sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_OPEN  = 3'b001,
		ST_ALARM = 3'b010,
		ST_SHORT = 3'b011,
		ST_UPD   = 3'b100
	} fdd_state_type;

endpackage

//--- rtl/fdd_decoder.sv
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

// Contract
// - Between open and alarm thresholds is healthy.
// - Above alarm is alarm; above short is shorted.
// - Three thresholds are writable configuration values.
// - Alarm states packed as signed 16-bit word.
// - Line-healthy bit clears on open or short.
// - Line-healthy bit returns without acknowledgement.
// - Line faults never raise module fault.
// - Status decided from three successive comparator readings.
// - Alarm bit is one exactly in alarm.
// - Alarm indicator on for alarm or short.
// - Fault indicator on for open or short.
module fdd_decoder
	import fdd_pkg::*;
(
	// Clock and reset.
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	// APB slave.
	input  wire logic [7:0]         paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Field side: reference level and the sixteen comparators.
	input  wire logic [NPTS-1:0]    comp_in,
	output logic      [15:0]        ref_level,
	// Point results and indicators.
	output logic signed [NPTS-1:0]  alarm_word,
	output logic      [NPTS-1:0]    line_ok,
	output logic      [NPTS-1:0]    alarm_led,
	output logic      [NPTS-1:0]    fault_led,
	// Module status and interrupt.
	output logic                    module_fault,
	output logic                    irq
);

	// Software-visible registers.
	logic               ctrl_en_ff;     // Scan enable.
	logic [15:0]        thr_open_ff;    // Open-circuit threshold.
	logic [15:0]        thr_alarm_ff;   // Alarm threshold.
	logic [15:0]        thr_short_ff;   // Short-circuit threshold.
	logic [IRQ_W-1:0]   irq_stat_ff;    // Sticky event bits.
	logic [IRQ_W-1:0]   irq_mask_ff;    // Interrupt enables.
	logic [15:0]        scan_cnt_ff;    // Completed scans, wraps.
	logic [31:0]        prdata_ff;      // Registered read data.
	logic               pslverr_ff;     // Registered error answer.

	// Thresholds frozen for the scan in progress.
	logic [15:0]        thr_open_q_ff;
	logic [15:0]        thr_alarm_q_ff;
	logic [15:0]        thr_short_q_ff;

	// Sequencer.
	fdd_state_type      state_ff;
	fdd_state_type      nxt_state;
	logic [CNT_W-1:0]   settle_ff;      // Cycles spent at this level.
	logic               level_done;     // Comparators have settled.
	logic               scan_start;     // A new scan opens on this edge.
	logic [15:0]        ref_level_ff;

	// Comparator snapshots, one per reference level.
	logic [NPTS-1:0]    cmp_open_ff;    // Current above open threshold.
	logic [NPTS-1:0]    cmp_alarm_ff;   // Current above alarm threshold.
	logic [NPTS-1:0]    cmp_short_ff;   // Current above short threshold.

	// Point results.
	logic [NPTS-1:0]    alarm_word_ff;
	logic [NPTS-1:0]    line_ok_ff;
	logic [NPTS-1:0]    alarm_led_ff;
	logic [NPTS-1:0]    fault_led_ff;
	logic               module_fault_ff;

	// Decoded classification of the current snapshot.
	logic [NPTS-1:0]    pt_open;
	logic [NPTS-1:0]    pt_short;
	logic [NPTS-1:0]    pt_alarm;
	logic [NPTS-1:0]    pt_incons;

	// Bus strobes.
	logic               wr_en;
	logic               rd_en;
	logic [IRQ_W-1:0]   irq_set;

	// True when the bus address hits the given offset.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// Reference level for a given state.
	function automatic logic [15:0] level_of(input fdd_state_type s,
		input logic [15:0] t_o, input logic [15:0] t_a, input logic [15:0] t_s);
		case (s)
			ST_OPEN:  level_of = t_o;
			ST_ALARM: level_of = t_a;
			ST_SHORT: level_of = t_s;
			default:  level_of = 16'h0000;
		endcase
	endfunction

	// Zero-wait APB: every access completes in its first access cycle.
	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign prdata  = prdata_ff;
	assign pslverr = pslverr_ff;

	// Control and threshold writes. Thresholds take effect at the next scan start.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_en_ff   <= CTRL_RST;
			thr_open_ff  <= OPEN_THR_RST;
			thr_alarm_ff <= ALARM_THR_RST;
			thr_short_ff <= SHORT_THR_RST;
			irq_mask_ff  <= IRQ_MASK_RST;
		end else if (wr_en) begin
			if (hit(paddr, ADDR_CTRL)) begin
				ctrl_en_ff <= pwdata[CTRL_EN_BIT];
			end else if (hit(paddr, ADDR_OPEN_THR)) begin
				thr_open_ff <= pwdata[15:0];
			end else if (hit(paddr, ADDR_ALARM_THR)) begin
				thr_alarm_ff <= pwdata[15:0];
			end else if (hit(paddr, ADDR_SHORT_THR)) begin
				thr_short_ff <= pwdata[15:0];
			end else if (hit(paddr, ADDR_IRQ_MASK)) begin
				irq_mask_ff <= pwdata[IRQ_W-1:0];
			end
		end
	end

	// Read mux and error answer; unmapped offsets read zero with pslverr.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
		end else begin
			prdata_ff  <= 32'h0000_0000;
			pslverr_ff <= 1'b0;
			if (psel && !penable) begin
				// Setup cycle: prepare the answer for the access cycle.
				if (hit(paddr, ADDR_CTRL)) begin
					prdata_ff[CTRL_EN_BIT] <= ctrl_en_ff;
				end else if (hit(paddr, ADDR_OPEN_THR)) begin
					prdata_ff[15:0] <= thr_open_ff;
				end else if (hit(paddr, ADDR_ALARM_THR)) begin
					prdata_ff[15:0] <= thr_alarm_ff;
				end else if (hit(paddr, ADDR_SHORT_THR)) begin
					prdata_ff[15:0] <= thr_short_ff;
				end else if (hit(paddr, ADDR_ALARM_WD)) begin
					prdata_ff[15:0] <= alarm_word_ff;
				end else if (hit(paddr, ADDR_LINE_OK)) begin
					prdata_ff[15:0] <= line_ok_ff;
				end else if (hit(paddr, ADDR_IRQ_STAT)) begin
					prdata_ff[IRQ_W-1:0] <= irq_stat_ff;
				end else if (hit(paddr, ADDR_IRQ_MASK)) begin
					prdata_ff[IRQ_W-1:0] <= irq_mask_ff;
				end else if (hit(paddr, ADDR_SCAN_STAT)) begin
					prdata_ff[15:0] <= scan_cnt_ff;
				end else begin
					pslverr_ff <= 1'b1;
				end
			end
		end
	end

	// Settle counter: restarts on every change of reference level.
	assign level_done = (settle_ff == CNT_W'(SETTLE_CYC - 1));
	assign scan_start = (state_ff == ST_IDLE || state_ff == ST_UPD) && (nxt_state == ST_OPEN);

	// Next-state logic of the scan sequencer: three levels, then commit.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (ctrl_en_ff) begin
					nxt_state = ST_OPEN;
				end
			end
			ST_OPEN: begin
				if (level_done) begin
					nxt_state = ST_ALARM;
				end
			end
			ST_ALARM: begin
				if (level_done) begin
					nxt_state = ST_SHORT;
				end
			end
			ST_SHORT: begin
				if (level_done) begin
					nxt_state = ST_UPD;
				end
			end
			ST_UPD: begin
				nxt_state = ctrl_en_ff ? ST_OPEN : ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// State, settle count and reference; a scan opens on the live open threshold.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff     <= ST_IDLE;
			settle_ff    <= '0;
			ref_level_ff <= 16'h0000;
		end else begin
			state_ff     <= nxt_state;
			settle_ff    <= (nxt_state != state_ff) ? '0 : settle_ff + CNT_W'(1);
			ref_level_ff <= scan_start ? thr_open_ff : level_of(nxt_state, thr_open_q_ff,
				thr_alarm_q_ff, thr_short_q_ff);
		end
	end
	assign ref_level = ref_level_ff;

	// Freeze thresholds at scan start so one scan never mixes two settings.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			thr_open_q_ff  <= OPEN_THR_RST;
			thr_alarm_q_ff <= ALARM_THR_RST;
			thr_short_q_ff <= SHORT_THR_RST;
		end else if (scan_start) begin
			thr_open_q_ff  <= thr_open_ff;
			thr_alarm_q_ff <= thr_alarm_ff;
			thr_short_q_ff <= thr_short_ff;
		end
	end

	// Comparator sampling on the last settled cycle of each level.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_open_ff  <= '0;
			cmp_alarm_ff <= '0;
			cmp_short_ff <= '0;
		end else if (level_done) begin
			if (state_ff == ST_OPEN) begin
				cmp_open_ff <= comp_in;
			end
			if (state_ff == ST_ALARM) begin
				cmp_alarm_ff <= comp_in;
			end
			if (state_ff == ST_SHORT) begin
				cmp_short_ff <= comp_in;
			end
		end
	end

	// Classification. A short outranks alarm; open means below the lowest level.
	assign pt_short  = cmp_short_ff;
	assign pt_open   = ~cmp_open_ff & ~cmp_short_ff;
	assign pt_alarm  = cmp_alarm_ff & cmp_open_ff & ~cmp_short_ff;
	// Readings out of order point to a broken comparator, not to the field wiring.
	assign pt_incons = (cmp_short_ff & ~cmp_alarm_ff) | (cmp_alarm_ff & ~cmp_open_ff);

	// Commit of all point outputs in one cycle, never between levels.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			alarm_word_ff <= '0;
			line_ok_ff    <= '1;
			alarm_led_ff  <= '0;
			fault_led_ff  <= '0;
		end else if (state_ff == ST_UPD) begin
			alarm_word_ff <= pt_alarm;
			line_ok_ff    <= ~(pt_open | pt_short);
			alarm_led_ff  <= pt_alarm | pt_short;
			fault_led_ff  <= pt_open | pt_short;
		end
	end
	assign alarm_word = alarm_word_ff;
	assign line_ok    = line_ok_ff;
	assign alarm_led  = alarm_led_ff;
	assign fault_led  = fault_led_ff;

	// Module fault follows only comparator consistency; line faults stay per point.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			module_fault_ff <= 1'b0;
		end else if (state_ff == ST_UPD) begin
			module_fault_ff <= |pt_incons;
		end
	end
	assign module_fault = module_fault_ff;

	// Scan counter gives software a heartbeat of the sequencer.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			scan_cnt_ff <= 16'h0000;
		end else if (state_ff == ST_UPD) begin
			scan_cnt_ff <= scan_cnt_ff + 16'h0001;
		end
	end

	// Events raised at commit: any change of alarm or line state, a new module fault, and every scan done.
	always_comb begin
		irq_set = '0;
		if (state_ff == ST_UPD) begin
			irq_set[IRQ_ALARM_BIT] = (pt_alarm != alarm_word_ff);
			irq_set[IRQ_LINE_BIT]  = (~(pt_open | pt_short) != line_ok_ff);
			irq_set[IRQ_MOD_BIT]   = (|pt_incons) && !module_fault_ff;
			irq_set[IRQ_SCAN_BIT]  = 1'b1;
		end
	end

	// Sticky status, write one to clear; a new event in the same cycle wins.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_ff <= '0;
		end else begin
			if (wr_en && hit(paddr, ADDR_IRQ_STAT)) begin
				irq_stat_ff <= (irq_stat_ff & ~pwdata[IRQ_W-1:0]) | irq_set;
			end else begin
				irq_stat_ff <= irq_stat_ff | irq_set;
			end
		end
	end
	assign irq = |(irq_stat_ff & irq_mask_ff);

	// Checks on the decoder's own outputs.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	healthy_vs_fault_a: assert property (line_ok_ff == ~fault_led_ff)
		else $error("line ok and fault indicator disagree");
	alarm_led_cover_a: assert property ((alarm_word_ff & ~alarm_led_ff) == '0)
		else $error("alarm bit set without alarm indicator");
	alarm_not_fault_a: assert property ((alarm_word_ff & fault_led_ff) == '0)
		else $error("alarm bit set on a faulted line");
	commit_only_upd_a: assert property ((state_ff != ST_UPD) |=>
		($stable(alarm_word_ff) && $stable(line_ok_ff) && $stable(alarm_led_ff)))
		else $error("point outputs changed outside commit");
	healthy_band_a: assert property ((state_ff == ST_UPD) |=>
		(line_ok_ff == ($past(cmp_open_ff | cmp_short_ff) & ~$past(cmp_short_ff))))
		else $error("healthy band decoded wrongly");
	line_recovers_a: assert property ((state_ff == ST_UPD && cmp_open_ff[0]
		&& !cmp_short_ff[0]) |=> line_ok_ff[0])
		else $error("line ok did not return without acknowledge");
	short_wins_a: assert property ((state_ff == ST_UPD && cmp_short_ff[3]) |=>
		(!alarm_word_ff[3] && alarm_led_ff[3] && fault_led_ff[3]))
		else $error("shorted line not decoded as short");
	level_order_a: assert property ((state_ff == ST_OPEN && level_done) |=>
		(state_ff == ST_ALARM && ref_level_ff == thr_alarm_q_ff) ##[1:200]
		(state_ff == ST_SHORT && ref_level_ff == thr_short_q_ff))
		else $error("reference levels out of sequence");
	thr_write_a: assert property ((wr_en && paddr == ADDR_SHORT_THR) |=>
		(thr_short_ff == $past(pwdata[15:0])))
		else $error("short threshold write lost");
	mod_fault_src_a: assert property ($rose(module_fault_ff) |->
		$past(pt_incons != '0))
		else $error("module fault raised without comparator fault");
	// Every commit must leave the scan-done event standing, even against a clear.
	scan_event_a: assert property ((state_ff == ST_UPD) |=> irq_stat_ff[IRQ_SCAN_BIT])
		else $error("scan done event lost at commit");
	alarm_seen_c:  cover property ((state_ff == ST_UPD) ##1 (alarm_word_ff != '0));
	fault_seen_c:  cover property ((state_ff == ST_UPD) ##1 (line_ok_ff != '1));
	recover_c:     cover property ($rose(line_ok_ff[0]));
	modfault_c:    cover property ($rose(module_fault_ff));
	irq_c:         cover property ($rose(irq));

endmodule

//--- verif/fdd_loop_model.sv
`timescale 1ns/1ps

// Field loops: each comparator says whether its loop current lies above the reference.
module fdd_loop_model
	import fdd_pkg::*;
(
	// Clock.
	input  wire logic                  ref_clk,
	// Reference level from the block and loop currents in microamps.
	input  wire logic [15:0]           ref_level,
	input  wire logic [NPTS-1:0][15:0] loop_ua,
	// A set bit inverts that comparator, standing for a broken input stage.
	input  wire logic [NPTS-1:0]       flip_cmp,
	// Comparator results towards the block.
	output logic      [NPTS-1:0]       comp_in
);
	// Registered, so the result lags the reference by a cycle, like a settling comparator.
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < NPTS; i++) begin
			comp_in[i] <= flip_cmp[i] ^ (loop_ua[i] > ref_level);
		end
	end
endmodule

//--- verif/tb.sv
`timescale 1ns/1ps

module tb
	import fdd_pkg::*;
;
	// Bench signals, one per design port.
	logic                  ref_clk = 1'b0;
	logic                  rst_n = 1'b0;
	logic [7:0]            paddr;
	logic                  psel;
	logic                  penable;
	logic                  pwrite;
	logic [31:0]           pwdata;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	logic [NPTS-1:0]       comp_in;
	logic [NPTS-1:0]       flip = '0;
	logic [15:0]           ref_level;
	logic signed [NPTS-1:0] alarm_word;
	logic [NPTS-1:0]       line_ok;
	logic [NPTS-1:0]       alarm_led;
	logic [NPTS-1:0]       fault_led;
	logic                  module_fault;
	logic                  irq;
	// Loop currents, thresholds the bench believes in, and expected scan results.
	logic [NPTS-1:0][15:0] loop_ua;
	logic [NPTS-1:0][15:0] cur;
	logic [15:0]           thr [3];
	logic [64:0]           exp_q [$];
	logic                  prev_zero = 1'b0;
	logic [31:0]           r;
	logic                  e;
	int                    error_cnt = 0;
	int                    checks_done = 0;
	int                    seed = 53107;

	fdd_decoder i_fdd_decoder (.ref_clk(ref_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .comp_in(comp_in), .ref_level(ref_level), .alarm_word(alarm_word),
		.line_ok(line_ok), .alarm_led(alarm_led), .fault_led(fault_led),
		.module_fault(module_fault), .irq(irq));
	fdd_loop_model i_fdd_loop_model (.ref_clk(ref_clk), .ref_level(ref_level), .loop_ua(loop_ua),
		.flip_cmp(flip), .comp_in(comp_in));

	// Free-running 100 MHz clock.
	always #5 ref_clk = ~ref_clk;

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("Errors %0d, checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Compares one seen value against its expectation.
	task automatic check(input logic [64:0] seen, input logic [64:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// One APB transfer; entered just after a rising edge, holds until pready is sampled.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			error_cnt++;
			print_verdict();
		end
		// Taken before the edge's own updates land, so this is the access-cycle value.
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	// Reads a register and compares data and error response.
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] d, input logic er);
		logic [31:0] v;
		logic        ve;
		apb(1'b0, a, 32'h0, v, ve);
		check(65'({v, ve}), 65'({d, er}));
	endtask

	// Waits, bounded, for the one-cycle update slot where the reference rests at zero.
	task automatic wait_upd();
		int n;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (ref_level !== 16'h0000 && n < 700);
		if (ref_level !== 16'h0000) begin
			error_cnt++;
			print_verdict();
		end
	endtask

	// Applies currents and comparator faults for one whole scan and notes what it must report.
	// Faults go on healthy loops only: an inverted comparator there reads above short yet
	// below open, so the point counts as shorted and the out-of-order readings flag the module.
	task automatic run_scan(input logic [NPTS-1:0][15:0] c, input logic [NPTS-1:0] f);
		logic [NPTS-1:0] op;
		logic [NPTS-1:0] al;
		logic [NPTS-1:0] sh;
		for (int i = 0; i < NPTS; i++) begin
			sh[i] = c[i] > thr[2] || f[i];
			op[i] = c[i] <= thr[0] && !f[i];
			al[i] = c[i] > thr[1] && !sh[i];
		end
		wait_upd();
		@(posedge ref_clk);
		loop_ua <= c;
		flip <= f;
		wait_upd();
		// Line faults never raise the module fault; only a broken comparator does.
		exp_q.push_back({al, ~(op | sh), al | sh, op | sh, |f});
	endtask

	// Picks a current strictly inside one of the four bands for every point.
	task automatic rand_pts();
		int unsigned k;
		int unsigned v;
		for (int i = 0; i < NPTS; i++) begin
			k = $unsigned($random(seed)) % 4;
			v = $unsigned($random(seed));
			case (k)
				0: cur[i] = 16'(v % thr[0]);
				1: cur[i] = 16'(thr[0] + 1 + v % (thr[1] - thr[0] - 1));
				2: cur[i] = 16'(thr[1] + 1 + v % (thr[2] - thr[1] - 1));
				default: cur[i] = 16'(thr[2] + 1 + v % (16'hffff - thr[2]));
			endcase
		end
	endtask

	// Result watcher: the edge after the update slot opens a scan on the open threshold
	// and carries a fresh scan result.
	always @(negedge ref_clk) begin
		if (rst_n && prev_zero && ref_level !== 16'h0000) begin
			check(65'(ref_level), 65'(thr[0]));
			if (exp_q.size() > 0) begin
				check({alarm_word, line_ok, alarm_led, fault_led, module_fault},
					exp_q.pop_front());
			end
		end
		prev_zero <= (ref_level === 16'h0000);
	end

	// Main sequence.
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		loop_ua = {NPTS{16'h1388}};
		thr = '{OPEN_THR_RST, ALARM_THR_RST, SHORT_THR_RST};
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd_chk(ADDR_CTRL, 32'h1, 1'b0);
		rd_chk(ADDR_OPEN_THR, {16'h0, OPEN_THR_RST}, 1'b0);
		rd_chk(ADDR_ALARM_THR, {16'h0, ALARM_THR_RST}, 1'b0);
		rd_chk(ADDR_SHORT_THR, {16'h0, SHORT_THR_RST}, 1'b0);
		rd_chk(8'h40, 32'h0, 1'b1);
		// Open, short and alarm on three points, with only line changes unmasked.
		apb(1'b1, ADDR_IRQ_MASK, 32'h2, r, e);
		cur = {NPTS{16'h1388}};
		cur[0] = 16'h03e8;
		cur[1] = 16'h7530;
		cur[2] = 16'h3a98;
		run_scan(cur, '0);
		@(negedge ref_clk);
		check(65'(irq), 65'(1));
		// Bus requests always start just after a rising edge.
		@(posedge ref_clk);
		apb(1'b1, ADDR_IRQ_STAT, 32'h2, r, e);
		check(65'(irq), 65'(0));
		// Faults clear with no acknowledgement once the loops are healthy again.
		run_scan({NPTS{16'h1388}}, '0);
		// A broken comparator flags the module; the next clean scan clears it.
		run_scan({NPTS{16'h1388}}, 16'h0020);
		repeat (12) begin
			rand_pts();
			run_scan(cur, '0);
		end
		// A lowered alarm threshold turns a healthy current into an alarm.
		@(posedge ref_clk);
		apb(1'b1, ADDR_ALARM_THR, 32'hffff1388, r, e);
		rd_chk(ADDR_ALARM_THR, 32'h00001388, 1'b0);
		apb(1'b1, ADDR_SHORT_THR, 32'h00004650, r, e);
		rd_chk(ADDR_SHORT_THR, 32'h00004650, 1'b0);
		thr[1] = 16'h1388;
		thr[2] = 16'h4650;
		run_scan({NPTS{16'h1b58}}, '0);
		repeat (2) @(posedge ref_clk);
		apb(1'b1, ADDR_ALARM_WD, 32'h0, r, e);
		check(65'(e), 65'(0));
		apb(1'b0, ADDR_ALARM_WD, 32'h0, r, e);
		check(65'(r[15:0]), 65'(16'hffff));
		repeat (4) begin
			rand_pts();
			run_scan(cur, '0);
		end
		repeat (2) wait_upd();
		check(65'(exp_q.size()), 65'(0));
		print_verdict();
	end
endmodule
